//--- include/scsi_bus_pkg.sv
/*
 * Constants, register layout and pin carriers for the SCSI target bus
 * signal layer. Assumes one 20 MHz core clock and an 8-bit register port.
 */
// Summary of operation
// R1: Eight active-low data lines, both directions.
// R2: Parity line carries odd parity per byte.
// R3: Attention is input; asserted means initiator attention.
// R4: Busy driven by bus owner, also monitored.
// R5: Initiator drives acknowledge low per byte.
// R6: Bus reset stops driving busy and select.
// R7: Bus reset clears arbitration and output enable.
// R8: Bus reset clears target enable bit.
// R9: Bus reset floats data, parity and phase lines.
// R10: Bus reset sets reset-detected bit.
// R11: Message line shows message phase.
// R12: Select driven to reselect an initiator.
// R13: Command/data low for control, high data.
// R14: Request line asserted for each handshake.
// R15: Input/output low means bytes to initiator.
// R16: Input/output level marks reselection versus selection.
// R17: Mode bit selects open-drain or push-pull.
// R18: Received bytes checked for odd parity.
// R19: Bus reset synchronised before touching registers.
`default_nettype none
package scsi_bus_pkg;
    // Register offsets.
    localparam logic [7:0] ADDR_DATA = 8'h50;
    localparam logic [7:0] ADDR_SEL_CTRL = 8'h52;
    localparam logic [7:0] ADDR_XFER_CTRL = 8'h53;
    localparam logic [7:0] ADDR_MODE = 8'h58;
    localparam logic [7:0] ADDR_ISTAT = 8'h44;
    localparam logic [7:0] ADDR_IMASK = 8'h45;
    localparam logic [7:0] ADDR_BSTAT = 8'h46;
    // Selection control fields.
    localparam int SEL_ARB = 0;
    localparam int SEL_RST_SEEN = 1;
    localparam int SEL_OUT_EN = 3;
    localparam int SEL_DRV_SELECT = 4;
    localparam int SEL_DRV_BUSY = 5;
    // Transfer control fields.
    localparam int XF_MSG = 0;
    localparam int XF_CMD = 1;
    localparam int XF_IN_OUT = 2;
    localparam int XF_REQ = 3;
    localparam int XF_TARGET_EN = 7;
    // Mode control field.
    localparam int MODE_OPEN_DRAIN = 3;
    // Interrupt status fields.
    localparam int EV_ATTN = 0;
    localparam int EV_PARITY = 1;
    localparam int EV_BUS_RESET = 2;
    localparam int EV_ACK = 3;
    // Reset values.
    localparam logic [7:0] RST_REG = 8'h00;

    // Raw pin levels as seen on the bus, all active low.
    typedef struct packed {
        logic [7:0] bus_data_lines_n;
        logic bus_parity_line_n;
        logic attn_n;
        logic busy_n;
        logic ack_n;
        logic bus_reset_input_n;
        logic select_n;
        logic in_out_n;
    } scsi_in_t;

    // Pin drive levels and output enables.
    typedef struct packed {
        logic [7:0] bus_data_lines_o;
        logic [7:0] bus_data_lines_oe;
        logic bus_parity_line_o;
        logic bus_parity_line_oe;
        logic busy_o;
        logic busy_oe;
        logic select_o;
        logic select_oe;
        logic msg_o;
        logic msg_oe;
        logic cmd_data_o;
        logic cmd_data_oe;
        logic in_out_o;
        logic in_out_oe;
        logic req_o;
        logic req_oe;
    } scsi_out_t;

    // Whole state of the bus layer.
    typedef struct packed {
        logic [7:0] sel_ctrl;
        logic [7:0] xfer_ctrl;
        logic [7:0] mode;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [7:0] istat;
        logic [7:0] imask;
        logic [7:0] rdata;
        logic rst_meta;
        logic rst_sync;
        logic ack_d;
        logic attn_d;
    } state_t;
endpackage
`default_nettype wire

//--- logic/scsi_target_bus.sv
/*
 * SCSI target bus signal layer: register port, pin drivers with
 * selectable open-drain mode, bus reset handling, parity and interrupts.
 * Assumes bus pins are resolved outside from the output enables.
 */
`timescale 1ns/1ps
`default_nettype none
module scsi_target_bus (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic IRQ_OUT,
    input wire scsi_bus_pkg::scsi_in_t BUS_IN,
    output scsi_bus_pkg::scsi_out_t BUS_OUT
);
    import scsi_bus_pkg::*;

    state_t st_r;
    state_t st_nxt;
    logic [7:0] ev;
    logic [7:0] rx_true;
    logic rx_par_ok;
    logic ack_fall;
    logic rst_now;
    logic od_mode;
    logic phase_en;
    logic data_en;

    localparam state_t ST_RST = '{
        sel_ctrl: RST_REG, xfer_ctrl: RST_REG, mode: RST_REG,
        tx_data: RST_REG, rx_data: RST_REG, istat: RST_REG,
        imask: RST_REG, rdata: RST_REG, rst_meta: 1'b0,
        rst_sync: 1'b0, ack_d: 1'b1, attn_d: 1'b1};

    // Maps an asserted flag and an enable onto a pin level and enable.
    function automatic logic [1:0] drive(input logic asrt, input logic en,
                                         input logic od);
        logic [1:0] r;
        r = 2'b00;
        if (od) begin
            r = {1'b0, en & asrt};
        end else begin
            r = {~asrt, en};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus observation.

    // Received byte in true polarity and its odd parity check.
    assign rx_true = ~BUS_IN.bus_data_lines_n; // see R1
    assign rx_par_ok = ^{rx_true, ~BUS_IN.bus_parity_line_n}; // see R18
    assign ack_fall = st_r.ack_d & ~BUS_IN.ack_n; // see R5
    // Raw reset level floats the pins at once; registers use the synced copy.
    assign rst_now = ~BUS_IN.bus_reset_input_n;

    // Events that set sticky interrupt status bits.
    always_comb begin
        ev = 8'h00;
        ev[EV_ATTN] = st_r.attn_d & ~BUS_IN.attn_n; // see R3
        ev[EV_ACK] = ack_fall;
        ev[EV_PARITY] = ack_fall & ~st_r.xfer_ctrl[XF_IN_OUT] & ~rx_par_ok; // see R18
        ev[EV_BUS_RESET] = st_r.rst_sync;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    // Register port, event capture and bus reset clearing.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_meta = rst_now; // see R19
        st_nxt.rst_sync = st_r.rst_meta; // see R19
        st_nxt.ack_d = BUS_IN.ack_n;
        st_nxt.attn_d = BUS_IN.attn_n;
        st_nxt.rdata = 8'h00;
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                ADDR_DATA: st_nxt.tx_data = REG_WDATA_IN;
                ADDR_SEL_CTRL: st_nxt.sel_ctrl = REG_WDATA_IN;
                ADDR_XFER_CTRL: st_nxt.xfer_ctrl = REG_WDATA_IN;
                ADDR_MODE: st_nxt.mode = REG_WDATA_IN;
                ADDR_IMASK: st_nxt.imask = REG_WDATA_IN;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                ADDR_DATA: st_nxt.rdata = st_r.rx_data;
                ADDR_SEL_CTRL: st_nxt.rdata = st_r.sel_ctrl;
                ADDR_XFER_CTRL: st_nxt.rdata = st_r.xfer_ctrl;
                ADDR_MODE: st_nxt.rdata = st_r.mode;
                ADDR_IMASK: st_nxt.rdata = st_r.imask;
                ADDR_ISTAT: begin
                    st_nxt.rdata = st_r.istat;
                    st_nxt.istat = 8'h00;
                end
                ADDR_BSTAT: begin
                    // Live bus levels in true polarity (bus reset from its synced copy), busy monitored here.
                    st_nxt.rdata = {1'b0, ~BUS_IN.in_out_n, ~BUS_IN.select_n,
                                    st_r.rst_sync, ~BUS_IN.ack_n,
                                    ~BUS_IN.busy_n, ~BUS_IN.attn_n,
                                    1'b0}; // see R4
                end
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        // Sticky events; a set in the clearing cycle wins.
        st_nxt.istat = st_nxt.istat | ev;
        if (ack_fall & ~st_r.xfer_ctrl[XF_IN_OUT]) begin
            st_nxt.rx_data = rx_true;
        end
        // Synchronised bus reset overrides software writes to the four bits it forces.
        if (st_r.rst_sync) begin
            st_nxt.sel_ctrl[SEL_ARB] = 1'b0; // see R7
            st_nxt.sel_ctrl[SEL_OUT_EN] = 1'b0; // see R7
            st_nxt.xfer_ctrl[XF_TARGET_EN] = 1'b0; // see R8
            st_nxt.sel_ctrl[SEL_RST_SEEN] = 1'b1; // see R10
        end
    end

    // All state registered in one place.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    assign od_mode = st_r.mode[MODE_OPEN_DRAIN]; // see R17
    assign phase_en = ~rst_now & st_r.sel_ctrl[SEL_OUT_EN] &
                      st_r.xfer_ctrl[XF_TARGET_EN]; // see R9
    // Data flows to the initiator only while input/output is asserted.
    assign data_en = phase_en & st_r.xfer_ctrl[XF_IN_OUT]; // see R15

    // One driver per data line.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_data
            assign {BUS_OUT.bus_data_lines_o[gi], BUS_OUT.bus_data_lines_oe[gi]} =
                drive(st_r.tx_data[gi], data_en, od_mode); // see R1
        end
    endgenerate

    // Parity, phase, request; busy and select are always open drain.
    assign {BUS_OUT.bus_parity_line_o, BUS_OUT.bus_parity_line_oe} =
        drive(~^st_r.tx_data, data_en, od_mode); // see R2
    assign {BUS_OUT.msg_o, BUS_OUT.msg_oe} =
        drive(st_r.xfer_ctrl[XF_MSG], phase_en, od_mode); // see R11
    assign {BUS_OUT.cmd_data_o, BUS_OUT.cmd_data_oe} =
        drive(st_r.xfer_ctrl[XF_CMD], phase_en, od_mode); // see R13
    assign {BUS_OUT.in_out_o, BUS_OUT.in_out_oe} =
        drive(st_r.xfer_ctrl[XF_IN_OUT], phase_en, od_mode); // see R16
    assign {BUS_OUT.req_o, BUS_OUT.req_oe} =
        drive(st_r.xfer_ctrl[XF_REQ], phase_en, od_mode); // see R14
    assign {BUS_OUT.busy_o, BUS_OUT.busy_oe} =
        drive(st_r.sel_ctrl[SEL_DRV_BUSY] | st_r.sel_ctrl[SEL_ARB],
              ~rst_now, 1'b1); // see R4 R6
    assign {BUS_OUT.select_o, BUS_OUT.select_oe} =
        drive(st_r.sel_ctrl[SEL_DRV_SELECT], ~rst_now, 1'b1); // see R12 R6

    // Register port and interrupt outputs.
    assign REG_RDATA_OUT = st_r.rdata;
    assign IRQ_OUT = |(st_r.istat & st_r.imask);

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    // Every check below runs on the core clock and sleeps in core reset.
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // Bus reset seen low on two edges in a row, long enough to pass the sync.
    sequence s_rst_held;
        !BUS_IN.bus_reset_input_n ##1 !BUS_IN.bus_reset_input_n;
    endsequence

    // An acknowledge edge while the initiator is sending us a byte.
    sequence s_rx_byte;
        $fell(BUS_IN.ack_n) && !st_r.xfer_ctrl[XF_IN_OUT];
    endsequence

    property p_float_rst;
        !BUS_IN.bus_reset_input_n |-> BUS_OUT.bus_data_lines_oe == 8'h00 &&
            !BUS_OUT.bus_parity_line_oe && !BUS_OUT.msg_oe &&
            !BUS_OUT.cmd_data_oe && !BUS_OUT.in_out_oe && !BUS_OUT.req_oe;
    endproperty
    a_float_rst: assert property (p_float_rst) else $error("pins driven in reset"); // see R9

    property p_bsy_sel_rst;
        !BUS_IN.bus_reset_input_n |-> !BUS_OUT.busy_oe && !BUS_OUT.select_oe;
    endproperty
    a_bsy_sel_rst: assert property (p_bsy_sel_rst) else $error("busy driven in reset"); // see R6

    property p_sync;
        s_rst_held |=> st_r.rst_sync;
    endproperty
    a_sync: assert property (p_sync) else $error("reset sync late"); // see R19

    property p_sel_clr;
        s_rst_held |=> ##1 !st_r.sel_ctrl[SEL_ARB] && !st_r.sel_ctrl[SEL_OUT_EN];
    endproperty
    a_sel_clr: assert property (p_sel_clr) else $error("select bits kept"); // see R7

    property p_tgt_clr;
        s_rst_held |=> ##1 !st_r.xfer_ctrl[XF_TARGET_EN];
    endproperty
    a_tgt_clr: assert property (p_tgt_clr) else $error("target bit kept"); // see R8

    property p_rst_seen;
        s_rst_held |=> ##1 st_r.sel_ctrl[SEL_RST_SEEN];
    endproperty
    a_rst_seen: assert property (p_rst_seen) else $error("reset not flagged"); // see R10

    property p_parity_out;
        BUS_OUT.bus_parity_line_oe && !od_mode |->
            ^{~BUS_OUT.bus_data_lines_o, ~BUS_OUT.bus_parity_line_o};
    endproperty
    a_parity_out: assert property (p_parity_out) else $error("parity not odd"); // see R2

    property p_parity_chk;
        s_rx_byte |=> st_r.istat[EV_PARITY] == !$past(rx_par_ok);
    endproperty
    a_parity_chk: assert property (p_parity_chk) else $error("parity flag wrong"); // see R18

    property p_open_drain;
        od_mode |-> BUS_OUT.bus_data_lines_o == 8'h00 && !BUS_OUT.req_o &&
            !BUS_OUT.cmd_data_o && !BUS_OUT.bus_parity_line_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain high"); // see R17

    property p_cmd_data;
        BUS_OUT.cmd_data_oe && !od_mode |->
            BUS_OUT.cmd_data_o == !st_r.xfer_ctrl[XF_CMD];
    endproperty
    a_cmd_data: assert property (p_cmd_data) else $error("command level wrong"); // see R13

    // An attention edge is the initiator asking for the target's notice.
    sequence s_attn_edge;
        $fell(BUS_IN.attn_n);
    endsequence

    // Every falling attention line must be caught in the status.
    property p_attn_evt;
        s_attn_edge |=> st_r.istat[EV_ATTN];
    endproperty
    a_attn_evt: assert property (p_attn_evt) else $error("attention not flagged"); // see R3

    // Every acknowledge from the initiator must be caught in the status.
    property p_ack_evt;
        $fell(BUS_IN.ack_n) |=> st_r.istat[EV_ACK];
    endproperty
    a_ack_evt: assert property (p_ack_evt) else $error("acknowledge not flagged"); // see R5

    // A received byte is latched in true polarity on the acknowledge edge.
    property p_rx_latch;
        s_rx_byte |=> st_r.rx_data == ~$past(BUS_IN.bus_data_lines_n);
    endproperty
    a_rx_latch: assert property (p_rx_latch) else $error("received byte wrong"); // see R1

    // No byte is taken from the bus while the target is sending.
    property p_rx_refused;
        $fell(BUS_IN.ack_n) && st_r.xfer_ctrl[XF_IN_OUT] |=> $stable(st_r.rx_data);
    endproperty
    a_rx_refused: assert property (p_rx_refused) else $error("byte taken in send"); // see R15

    // A set busy bit pulls the busy line low unless the bus is in reset.
    property p_busy_drive;
        st_r.sel_ctrl[SEL_DRV_BUSY] && BUS_IN.bus_reset_input_n |->
            BUS_OUT.busy_oe && !BUS_OUT.busy_o;
    endproperty
    a_busy_drive: assert property (p_busy_drive) else $error("busy not driven"); // see R4

    // A set select bit pulls the select line low for a reselection.
    property p_select_drive;
        st_r.sel_ctrl[SEL_DRV_SELECT] && BUS_IN.bus_reset_input_n |->
            BUS_OUT.select_oe && !BUS_OUT.select_o;
    endproperty
    a_select_drive: assert property (p_select_drive) else $error("select not driven"); // see R12

    // Message line level follows the phase bit when actively driven.
    property p_msg_drive;
        BUS_OUT.msg_oe && !od_mode |-> BUS_OUT.msg_o == !st_r.xfer_ctrl[XF_MSG];
    endproperty
    a_msg_drive: assert property (p_msg_drive) else $error("message level wrong"); // see R11

    // An enabled request bit always pulls the request line low.
    property p_req_drive;
        st_r.xfer_ctrl[XF_REQ] && phase_en |-> BUS_OUT.req_oe && !BUS_OUT.req_o;
    endproperty
    a_req_drive: assert property (p_req_drive) else $error("request not driven"); // see R14

    // Data lines are driven only while the direction is towards the initiator.
    property p_data_dir;
        BUS_OUT.bus_data_lines_oe != 8'h00 |-> BUS_OUT.in_out_oe && !BUS_OUT.in_out_o;
    endproperty
    a_data_dir: assert property (p_data_dir) else $error("data against direction"); // see R15

    // Input/output level follows the direction bit when actively driven.
    property p_in_out_level;
        BUS_OUT.in_out_oe && !od_mode |->
            BUS_OUT.in_out_o == !st_r.xfer_ctrl[XF_IN_OUT];
    endproperty
    a_in_out_level: assert property (p_in_out_level) else $error("io level wrong"); // see R16

    // Push-pull mode drives every enabled phase line, asserted or not.
    property p_push_pull;
        !od_mode && phase_en |-> BUS_OUT.req_oe && BUS_OUT.msg_oe && BUS_OUT.cmd_data_oe;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull line floated"); // see R17

    // In open-drain mode an odd number of data and parity lines is pulled low.
    property p_parity_od;
        od_mode && data_en |-> ^{BUS_OUT.bus_data_lines_oe, BUS_OUT.bus_parity_line_oe};
    endproperty
    a_parity_od: assert property (p_parity_od) else $error("open-drain parity even"); // see R2

    // Read data stand one cycle after a read strobe and are zero otherwise.
    property p_rdata_idle;
        !REG_RD_IN |=> REG_RDATA_OUT == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    // A read of the status clears it unless a new event lands at once.
    property p_istat_clr;
        REG_RD_IN && REG_ADDR_IN == ADDR_ISTAT && ev == 8'h00 |=> st_r.istat == 8'h00;
    endproperty
    a_istat_clr: assert property (p_istat_clr) else $error("status not cleared");

    // The synchronised bus reset keeps its status bit set.
    property p_rst_evt;
        st_r.rst_sync |=> st_r.istat[EV_BUS_RESET];
    endproperty
    a_rst_evt: assert property (p_rst_evt) else $error("bus reset not flagged"); // see R10
endmodule
`default_nettype wire

//--- verif/scsi_initiator_model.sv
/* Initiator on the shared bus: pulls every line up, answers requests
   with acknowledge and sends bytes. Assumes the target's pin carriers. */
`timescale 1ns/1ps
`default_nettype none
module scsi_initiator_model (
    input wire logic clk,
    input wire scsi_bus_pkg::scsi_out_t dev,
    input wire logic [7:0] tx_byte,
    input wire logic bad_par,
    input wire logic attn,
    input wire logic bus_reset_input,
    input wire logic [3:0] ack_dly,
    output scsi_bus_pkg::scsi_in_t pins,
    output logic [8:0] seen,
    output logic [2:0] phase
);
    import scsi_bus_pkg::*;
    logic ack_n = 1'b1;
    logic drv;
    logic req_n;
    // A line is low only while a party drives it low; otherwise pulled up.
    assign drv = ~dev.in_out_oe | dev.in_out_o;
    assign req_n = ~dev.req_oe | dev.req_o;
    // Our bytes go out only while the target lets data flow from us.
    always_comb begin
        pins.bus_data_lines_n = (~dev.bus_data_lines_oe | dev.bus_data_lines_o)
            & (drv ? ~tx_byte : 8'hFF);
        pins.bus_parity_line_n = (~dev.bus_parity_line_oe | dev.bus_parity_line_o)
            & (drv ? (^tx_byte ^ bad_par) : 1'b1);
        pins.attn_n = ~attn;
        pins.busy_n = ~dev.busy_oe | dev.busy_o;
        pins.ack_n = ack_n;
        pins.bus_reset_input_n = ~bus_reset_input;
        pins.select_n = ~dev.select_oe | dev.select_o;
        pins.in_out_n = drv;
    end
    // Answer each request after a set delay, latching what the target shows.
    always @(posedge clk) begin
        if (!req_n && ack_n) begin
            repeat (ack_dly) @(posedge clk);
            seen <= ~{pins.bus_parity_line_n, pins.bus_data_lines_n};
            phase <= {~dev.msg_oe | dev.msg_o, ~dev.cmd_data_oe | dev.cmd_data_o, drv};
            ack_n <= 1'b0;
            while (!req_n) @(posedge clk);
            ack_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- verif/scsi_target_bus_tb.sv
/* Self-checking bench for the SCSI target bus layer. Assumes the
   initiator model on the far side and the register port of the design. */
`timescale 1ns/1ps
`default_nettype none
module scsi_target_bus_tb;
    import scsi_bus_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic irq;
    scsi_in_t bin;
    scsi_out_t bout;
    logic [7:0] tx = 8'h00;
    logic bad = 1'b0;
    logic attn = 1'b0;
    logic bus_reset_input = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [8:0] seen;
    logic [2:0] phase;
    logic [7:0] b;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 82;
    int exp_q[$];

    // Core clock at 20 MHz.
    always #25 clk = ~clk;

    scsi_target_bus uut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
        .IRQ_OUT(irq), .BUS_IN(bin), .BUS_OUT(bout));
    scsi_initiator_model peer (.clk(clk), .dev(bout), .tx_byte(tx), .bad_par(bad),
        .attn(attn), .bus_reset_input(bus_reset_input), .ack_dly(dly), .pins(bin), .seen(seen), .phase(phase));

    //////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compares a byte result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    // Compares a single line or flag.
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // One-cycle read; data stand only in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask
    // Raises request, waits for acknowledge, then drops request.
    task automatic xfer(input logic [7:0] ctl);
        int i;
        wr(ADDR_XFER_CTRL, ctl);
        for (i = 0; i < 40 && bin.ack_n !== 1'b0; i++) @(posedge clk);
        chk1(bin.ack_n, 1'b0);
        wr(ADDR_XFER_CTRL, ctl & 8'hF7);
        repeat (3) @(posedge clk);
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    //////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_SEL_CTRL, RST_REG);
        rd(ADDR_XFER_CTRL, RST_REG);
        rd(ADDR_MODE, RST_REG);
        rd(8'h60, 8'h00);
        wr(ADDR_IMASK, 8'h0A);
        rd(ADDR_IMASK, 8'h0A);
        wr(ADDR_SEL_CTRL, 8'h08);
        // Send bytes in both drive modes and every control phase.
        for (int m = 0; m < 8; m++) begin
            b = 8'($random(seed));
            exp_q.push_back(b);
            wr(ADDR_MODE, m[0] ? 8'h08 : 8'h00);
            wr(ADDR_DATA, b);
            dly <= 4'(m);
            xfer(8'h8C | {6'h0, m[1], m[2]});
            chk8(seen[7:0], 8'(exp_q.pop_front()));
            chk1(seen[8], ~^b);
            chk8({5'h0, phase}, {5'h0, ~m[2], ~m[1], 1'b0});
            chk1(bout.req_oe, !m[0]);
            chk1(irq, 1'b1);
            rd(ADDR_ISTAT, 8'h08);
            chk1(irq, 1'b0);
        end
        // Receive bytes with good and broken parity.
        for (int m = 0; m < 4; m++) begin
            b = 8'($random(seed));
            @(posedge clk);
            tx <= b;
            bad <= m[0];
            xfer(8'h88);
            rd(ADDR_DATA, b);
            rd(ADDR_ISTAT, m[0] ? 8'h0A : 8'h08);
        end
        // A masked attention still lands in the status.
        @(posedge clk);
        attn <= 1'b1;
        repeat (4) @(posedge clk);
        chk1(irq, 1'b0);
        rd(ADDR_ISTAT, 8'h01);
        @(posedge clk);
        attn <= 1'b0;
        // Bus reset floats the lines and clears the arbitration, output-enable and target-enable bits; busy and select bits stay.
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_SEL_CTRL, 8'h39);
        wr(ADDR_XFER_CTRL, 8'h87);
        #1;
        chk1(bout.busy_oe & bout.select_oe & bout.msg_oe, 1'b1);
        rd(ADDR_BSTAT, 8'h64);
        @(posedge clk);
        bus_reset_input <= 1'b1;
        #1;
        chk1(bout.busy_oe | bout.select_oe, 1'b0);
        chk1(|{bout.bus_data_lines_oe, bout.bus_parity_line_oe, bout.in_out_oe,
            bout.cmd_data_oe, bout.msg_oe, bout.req_oe}, 1'b0);
        repeat (4) @(posedge clk);
        rd(ADDR_BSTAT, 8'h10);
        rd(ADDR_SEL_CTRL, 8'h32);
        rd(ADDR_XFER_CTRL, 8'h07);
        rd(ADDR_ISTAT, 8'h04);
        @(posedge clk);
        bus_reset_input <= 1'b0;
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
